// ===== ixs_pkg.sv
// package: opcodes, widths, field positions and reset values for the execute subset
package ixs_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8; // data path width
    localparam int FADDR_W = 7; // file register address width
    localparam int PC_W = 13; // program counter width
    localparam int LIT11_W = 11; // jump literal width
    localparam int INSN_W = 14; // instruction word width

    // ------------------------------------------------------------
    // field positions inside the 14-bit word
    // ------------------------------------------------------------
    localparam int DEST_BIT = 7; // destination select bit
    localparam int LATCH_HI = 4; // latch bit feeding pc bit 12
    localparam int LATCH_LO = 3; // latch bit feeding pc bit 11

    // ------------------------------------------------------------
    // opcode patterns (upper bits of the word)
    // ------------------------------------------------------------
    localparam logic [2:0] OP_JUMP = 3'h5; // bits 13:11 = 101
    localparam logic [5:0] OP_ORLIT = 6'h38; // bits 13:8 = 111000
    localparam logic [5:0] OP_INCREMENT_FILE = 6'h0a; // bits 13:8 = 001010
    localparam logic [5:0] OP_ORWF = 6'h04; // bits 13:8 = 000100
    localparam logic [5:0] OP_MOVE_FILE = 6'h08; // bits 13:8 = 001000

    // ------------------------------------------------------------
    // reset values and cycle counts
    // ------------------------------------------------------------
    localparam logic [12:0] PC_RST = 13'h0000; // program counter after reset
    localparam logic [7:0] ACC_RST = 8'h00; // accumulator after reset
    localparam logic [7:0] FILE_RST = 8'h00; // file register reset value; not applied, the file memory has no reset
    localparam int JUMP_CYCLES = 2; // jump occupies two instruction cycles

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        IXS_NONE,
        IXS_JUMP,
        IXS_ORLIT,
        IXS_INCREMENT_FILE,
        IXS_ORWF,
        IXS_MOVE_FILE
    } ixs_op_e;

    // instruction request bundle
    typedef struct packed {
        logic valid; // word offered this cycle
        logic [INSN_W-1:0] word; // instruction word
    } ixs_insn_s;

    // architectural status bundle
    typedef struct packed {
        logic [PC_W-1:0] pc; // program counter
        logic [DATA_W-1:0] acc; // accumulator
        logic zero; // zero flag
    } ixs_arch_s;
endpackage

// ===== ixs_file_mem.sv
// file register memory: one write port, registered read port
`timescale 1ns/10ps
`default_nettype none
module ixs_file_mem #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // write port
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [DW-1:0] wr_data_i,
    // read port
    input wire logic [AW-1:0] rd_addr_i,
    output logic [DW-1:0] rd_data_o
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [DW-1:0] mem_r [2**AW]; // file cells

    initial begin
        if (AW < 1 || DW < 1) begin
            $error("ixs_file_mem: bad width");
        end
    end

    // write on the edge, read data from a register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= mem_r[rd_addr_i];
        end
    end

    // storage array has no reset; cleared by software in practice
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
    end
endmodule
`default_nettype wire

// ===== ixs_exec.sv
// execute unit for jump, or-literal, increment, or-with-file and move-file
//
// How it works
// - jump loads 11-bit literal into pc low
// - jump fills pc high from latch bits
// - jump is unconditional, two cycles
// - or literal into accumulator, update zero
// - increment addressed file, update zero
// - or accumulator with file, update zero
// - dest bit: 0 accumulator, 1 file
// - move file to destination, update zero
// - move file takes two cycles
`timescale 1ns/10ps
`default_nettype none
module ixs_exec #(
    parameter int FADDR_W = ixs_pkg::FADDR_W
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // instruction request
    input wire ixs_pkg::ixs_insn_s insn_i,
    input wire logic [ixs_pkg::DATA_W-1:0] pc_high_latch_i,
    output logic insn_ready_o,
    // architectural state
    output ixs_pkg::ixs_arch_s arch_o,
    output logic retire_o
);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    initial begin
        if (FADDR_W != ixs_pkg::FADDR_W) begin
            $error("ixs_exec: file address width must be 7");
        end
    end

    // ------------------------------------------------------------
    // reset synchroniser
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r; // two-stage release
    logic rst_n; // synchronised reset

    // async assert, two-edge release
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_FLUSH
    } ixs_st_e;

    typedef struct packed {
        ixs_st_e st; // sequencer state
        ixs_pkg::ixs_op_e op; // held operation
        logic [ixs_pkg::INSN_W-1:0] word; // held word
        ixs_pkg::ixs_arch_s arch; // pc, accumulator, zero
        logic retire; // retire pulse
    } ixs_state_s;

    ixs_state_s s_r; // registered state
    ixs_state_s s_nxt; // next state

    // memory port wires
    logic mem_we; // file write strobe
    logic [FADDR_W-1:0] mem_wa; // write address
    logic [ixs_pkg::DATA_W-1:0] mem_wd; // write data
    logic [FADDR_W-1:0] mem_ra; // read address
    logic [ixs_pkg::DATA_W-1:0] mem_rd; // registered read data

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // opcode decode of the new word; the held word's op is kept in s_r.op
    function automatic ixs_pkg::ixs_op_e decode(input logic [ixs_pkg::INSN_W-1:0] w);
        if (w[13:11] == ixs_pkg::OP_JUMP) begin
            return ixs_pkg::IXS_JUMP;
        end
        case (w[13:8])
            ixs_pkg::OP_ORLIT: return ixs_pkg::IXS_ORLIT;
            ixs_pkg::OP_INCREMENT_FILE: return ixs_pkg::IXS_INCREMENT_FILE;
            ixs_pkg::OP_ORWF: return ixs_pkg::IXS_ORWF;
            ixs_pkg::OP_MOVE_FILE: return ixs_pkg::IXS_MOVE_FILE;
            default: return ixs_pkg::IXS_NONE;
        endcase
    endfunction

    // zero test shared by every flag-writing op
    function automatic logic is_zero(input logic [ixs_pkg::DATA_W-1:0] v);
        return (v == '0);
    endfunction

    // ------------------------------------------------------------
    // file memory
    // ------------------------------------------------------------
    ixs_file_mem #(
        .AW(FADDR_W),
        .DW(ixs_pkg::DATA_W)
    ) u_file (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .wr_en_i(mem_we),
        .wr_addr_i(mem_wa),
        .wr_data_i(mem_wd),
        .rd_addr_i(mem_ra),
        .rd_data_o(mem_rd)
    );

    // read address comes straight from the offered word
    assign mem_ra = insn_i.word[FADDR_W-1:0];

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [ixs_pkg::DATA_W-1:0] res; // alu result
        res = '0;
        s_nxt = s_r;
        s_nxt.retire = 1'b0;
        mem_we = 1'b0;
        mem_wa = s_r.word[FADDR_W-1:0];
        mem_wd = '0;
        case (s_r.st)
            // take a new word
            ST_IDLE: begin
                if (insn_i.valid) begin
                    s_nxt.word = insn_i.word;
                    s_nxt.op = decode(insn_i.word);
                    case (decode(insn_i.word))
                        ixs_pkg::IXS_JUMP: begin
                            s_nxt.arch.pc[ixs_pkg::LIT11_W-1:0] = insn_i.word[ixs_pkg::LIT11_W-1:0];
                            s_nxt.arch.pc[12:11] = {pc_high_latch_i[ixs_pkg::LATCH_HI],
                                                    pc_high_latch_i[ixs_pkg::LATCH_LO]};
                            s_nxt.st = ST_FLUSH;
                        end
                        ixs_pkg::IXS_ORLIT: begin
                            res = s_r.arch.acc | insn_i.word[7:0];
                            s_nxt.arch.acc = res;
                            s_nxt.arch.zero = is_zero(res);
                            s_nxt.arch.pc = s_r.arch.pc + 13'h0001;
                            s_nxt.retire = 1'b1;
                        end
                        // file ops wait one edge for read data
                        ixs_pkg::IXS_INCREMENT_FILE, ixs_pkg::IXS_ORWF, ixs_pkg::IXS_MOVE_FILE: begin
                            s_nxt.st = ST_READ;
                        end
                        // other words just advance the pc
                        default: begin
                            s_nxt.arch.pc = s_r.arch.pc + 13'h0001;
                            s_nxt.retire = 1'b1;
                        end
                    endcase
                end
            end
            // file op completes in its second instruction cycle
            ST_READ: begin
                case (s_r.op)
                    ixs_pkg::IXS_INCREMENT_FILE: res = mem_rd + 8'h01;
                    ixs_pkg::IXS_ORWF: res = s_r.arch.acc | mem_rd;
                    ixs_pkg::IXS_MOVE_FILE: res = mem_rd;
                    default: res = mem_rd;
                endcase
                s_nxt.arch.zero = is_zero(res);
                if (s_r.word[ixs_pkg::DEST_BIT]) begin
                    mem_we = 1'b1;
                    mem_wd = res;
                end else begin
                    s_nxt.arch.acc = res;
                end
                s_nxt.arch.pc = s_r.arch.pc + 13'h0001;
                s_nxt.retire = 1'b1;
                s_nxt.st = ST_IDLE;
            end
            // second jump cycle, no flags touched
            ST_FLUSH: begin
                s_nxt.retire = 1'b1;
                s_nxt.st = ST_IDLE;
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_r.st <= ST_IDLE;
            s_r.op <= ixs_pkg::IXS_NONE;
            s_r.word <= '0;
            s_r.arch.pc <= ixs_pkg::PC_RST;
            s_r.arch.acc <= ixs_pkg::ACC_RST;
            s_r.arch.zero <= 1'b0;
            s_r.retire <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // ready only when idle; the word is held off otherwise
    assign insn_ready_o = (s_r.st == ST_IDLE);
    assign arch_o = s_r.arch;
    assign retire_o = s_r.retire;
endmodule
`default_nettype wire

// ===== ixs_exec_sva.sv
// checker: port-level relations of the execute unit
`timescale 1ns/10ps
`default_nettype none
module ixs_exec_sva (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // watched ports
    input wire ixs_pkg::ixs_insn_s insn_i,
    input wire logic [ixs_pkg::DATA_W-1:0] pc_high_latch_i,
    input wire logic insn_ready_o,
    input wire ixs_pkg::ixs_arch_s arch_o,
    input wire logic retire_o
);
    // ------------------------------------------------------------
    // decode of the word at the take edge
    // ------------------------------------------------------------
    wire logic take = insn_i.valid && insn_ready_o; // word accepted
    wire logic is_jump = take && (insn_i.word[13:11] == ixs_pkg::OP_JUMP);
    wire logic is_orlit = take && (insn_i.word[13:8] == ixs_pkg::OP_ORLIT);
    wire logic is_file = take && (insn_i.word[13:8] inside {ixs_pkg::OP_INCREMENT_FILE, ixs_pkg::OP_ORWF, ixs_pkg::OP_MOVE_FILE});
    wire logic [7:0] or_res = arch_o.acc | insn_i.word[7:0]; // or-literal result

    // raw reset is enough: no take happens while the synced copy lags
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    jump_pc_low_a: assert property (
        is_jump |=> arch_o.pc[10:0] == $past(insn_i.word[10:0])) else $error("jump low pc bits wrong");
    jump_pc_high_a: assert property (
        is_jump |=> arch_o.pc[12:11] == $past(pc_high_latch_i[4:3])) else $error("jump high pc bits wrong");
    jump_two_cyc_a: assert property (
        is_jump |=> !retire_o && !insn_ready_o ##1 retire_o) else $error("jump retire timing wrong");
    jump_keeps_zero_a: assert property (
        is_jump |=> $stable(arch_o.zero) [*2]) else $error("jump changed zero flag");
    orlit_result_a: assert property (
        is_orlit |=> retire_o && arch_o.acc == $past(or_res) && arch_o.zero == ($past(or_res) == 8'h00))
        else $error("or literal result wrong");
    file_op_time_a: assert property (
        is_file |=> !insn_ready_o && !retire_o ##1 retire_o) else $error("file op timing wrong");
    dest_file_acc_a: assert property (
        is_file && insn_i.word[7] |=> $stable(arch_o.acc) [*2]) else $error("file dest touched acc");
    zero_follows_a: assert property (
        $changed(arch_o.acc) |-> arch_o.zero == (arch_o.acc == 8'h00)) else $error("zero flag mismatch");

    // main scenarios reached
    cover property (is_jump);
    cover property (is_file && insn_i.word[7]);
    cover property (retire_o && arch_o.zero);
endmodule

bind ixs_exec ixs_exec_sva chk_u (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .insn_i(insn_i),
    .pc_high_latch_i(pc_high_latch_i),
    .insn_ready_o(insn_ready_o),
    .arch_o(arch_o),
    .retire_o(retire_o)
);
`default_nettype wire

// ===== instruction_execute_subset_tb.sv
// testbench: directed instruction sequences for the execute unit
`timescale 1ns/10ps
`default_nettype none
module instruction_execute_subset_tb;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0; // held low from time zero
    ixs_pkg::ixs_insn_s insn_i = '0;
    logic [7:0] pc_high_latch_i = 8'h00;
    logic insn_ready_o;
    ixs_pkg::ixs_arch_s arch_o;
    logic retire_o;
    int num_errors = 0;
    int compares = 0;

    ixs_exec dut_u (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .insn_i(insn_i),
        .pc_high_latch_i(pc_high_latch_i),
        .insn_ready_o(insn_ready_o),
        .arch_o(arch_o),
        .retire_o(retire_o)
    );

    // 8 ns clock
    initial begin
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // offer a word, wait for take, then judge cycles and state at retire
    task automatic run(input string nm, input logic [13:0] w, input int cyc, input logic [7:0] acc_e,
                       input logic z_e, input logic [12:0] pc_e);
        int n;
        logic r;
        @(posedge sys_clk_i);
        insn_i <= '{valid: 1'b1, word: w};
        // ready sampled mid-cycle so the take edge is known without a race
        do begin
            @(negedge sys_clk_i);
            r = insn_ready_o;
            @(posedge sys_clk_i);
        end while (r !== 1'b1);
        insn_i.valid <= 1'b0;
        n = 0;
        // bounded wait: no op here takes more than two cycles
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (retire_o !== 1'b1 && n < 5);
        check({nm, " cycles"}, 16'(n), 16'(cyc));
        check({nm, " pc"}, {3'h0, arch_o.pc}, {3'h0, pc_e});
        check({nm, " acc"}, {8'h00, arch_o.acc}, {8'h00, acc_e});
        check({nm, " zero"}, {15'h0, arch_o.zero}, {15'h0, z_e});
    endtask

    task automatic summarize();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence: file 5 gets ff via or with all-ones acc,
    // since the file memory has no reset value of its own
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        // values left by reset, judged mid-cycle once the synced copy has lifted
        @(negedge sys_clk_i);
        check("reset pc", {3'h0, arch_o.pc}, {3'h0, ixs_pkg::PC_RST});
        check("reset acc", {8'h00, arch_o.acc}, {8'h00, ixs_pkg::ACC_RST});
        check("reset zero", {15'h0, arch_o.zero}, 16'h0000);
        check("reset ready", {15'h0, insn_ready_o}, 16'h0001);
        check("reset retire", {15'h0, retire_o}, 16'h0000);
        run("orlit ff", 14'h38ff, 1, 8'hff, 1'b0, 13'h0001);
        run("orwf d1", 14'h0485, 2, 8'hff, 1'b0, 13'h0002);
        run("increment_file wrap", 14'h0a85, 2, 8'hff, 1'b1, 13'h0003);
        run("move_file d0", 14'h0805, 2, 8'h00, 1'b1, 13'h0004);
        run("increment_file d0", 14'h0a05, 2, 8'h01, 1'b0, 13'h0005);
        run("move_file d1", 14'h0885, 2, 8'h01, 1'b1, 13'h0006);
        run("orwf d0", 14'h0405, 2, 8'h01, 1'b0, 13'h0007);
        run("orlit 00", 14'h3800, 1, 8'h01, 1'b0, 13'h0008);
        run("other", 14'h0000, 1, 8'h01, 1'b0, 13'h0009);
        // latch changes on a rising edge, never mid-cycle
        @(posedge sys_clk_i);
        pc_high_latch_i <= 8'h18;
        run("jump top", 14'h2fff, 2, 8'h01, 1'b0, 13'h1fff);
        @(posedge sys_clk_i);
        pc_high_latch_i <= 8'he7;
        run("jump zero", 14'h2800, 2, 8'h01, 1'b0, 13'h0000);
        summarize();
    end

    // hang guard: the sequence needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge sys_clk_i);
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
